// [rtl/six_channel_power_pwm.v]
`timescale 1ns/1ns
`include "power_pwm_regs.vh"
module six_channel_power_pwm #(
   parameter N = `PWM_CHANNELS,
   parameter W = `PWM_CNT_W,
   parameter BW = `PWM_BLANK_W
) (
   input wire clk, // Timebase clock, one tick per edge step.
   input wire rst_n, // Synchronous reset, active low.
   input wire [2*N-1:0] chanMode, // Two mode bits per channel.
   input wire [N-1:0] swapOut, // Exchange low and high outputs.
   input wire [N-1:0] chopEn, // Gate chopper onto outputs.
   input wire [7:0] chopDiv, // Chopper half period in clocks, minus one.
   input wire [N-1:0] extRstEn, // External short-cycle reset enable.
   input wire [N-1:0] extRstVarPeriod, // One: period restarts on reset.
   input wire [N-1:0] extRstIn, // External short-cycle reset inputs.
   input wire [N*W-1:0] cfgPeriod, // Per channel period.
   input wire [N*W-1:0] cfgDuty, // Per channel duty (high side).
   input wire [N*W-1:0] cfgDuty2, // Per channel second duty (dual mode).
   input wire [N*W-1:0] cfgPhase, // Per channel phase offset.
   input wire [N*W-1:0] cfgDead, // Per channel dead time.
   input wire [N-1:0] cfgWrite, // Load individual settings.
   input wire [N-1:0] groupAMember, // Channels in group A.
   input wire [N-1:0] groupBMember, // Channels in group B.
   input wire groupAWrite, // Load group A settings to all members.
   input wire groupBWrite, // Load group B settings to all members.
   input wire [W-1:0] grpAPeriod, // Group A period.
   input wire [W-1:0] grpADuty, // Group A duty.
   input wire [W-1:0] grpAPhase, // Group A phase.
   input wire [W-1:0] grpBPeriod, // Group B period.
   input wire [W-1:0] grpBDuty, // Group B duty.
   input wire [W-1:0] grpBPhase, // Group B phase.
   input wire updImmediate, // One: apply now; zero: at end of period.
   input wire [N-1:0] faultCmp, // Comparator fault per channel.
   input wire [N-1:0] faultExt, // External fault per channel.
   input wire [N-1:0] faultSel, // One selects external fault.
   input wire [N-1:0] limitCmp, // Comparator current limit per channel.
   input wire [N-1:0] limitExt, // External current limit per channel.
   input wire [N-1:0] limitSel, // One selects external limit.
   input wire [BW-1:0] blankTime, // Leading edge blanking for triggers.
   output reg [N-1:0] pwm_low_side_out, // Low-side outputs.
   output reg [N-1:0] pwm_high_side_out, // High-side outputs.
   output reg adcTrigRise, // Pulse on a rising channel 0 high-side edge.
   output reg adcTrigFall, // Pulse on a falling channel 0 high-side edge.
   output reg [N-1:0] faultActive // Selected fault present.
);
   reg [7:0] chopCnt_q;
   reg chopClk_q;
   reg [BW-1:0] blankCnt_q;
   reg [N-1:0] riseEv;
   reg [N-1:0] fallEv;
   integer k;
   // Free-running chopper shared by all channels.
   always @(posedge clk) begin
      if (!rst_n) begin
         chopCnt_q <= 8'h00;
         chopClk_q <= 1'b0;
      end else if (chopCnt_q >= chopDiv) begin
         chopCnt_q <= 8'h00;
         chopClk_q <= ~chopClk_q;
      end else begin
         chopCnt_q <= chopCnt_q + 8'h01;
      end
   end
   genvar i;
   generate
      for (i = 0; i < N; i = i + 1) begin : g_ch
         reg [W-1:0] per_q, duty_q, duty2_q, phase_q, dead_q;
         reg [W-1:0] pPer_q, pDuty_q, pDuty2_q, pPhase_q, pDead_q;
         reg pend_q;
         reg cut_q;
         reg [W-1:0] cnt_q;
         reg rawH_q;
         reg [W-1:0] dtCnt_q;
         reg outH_q, outL_q;
         reg prevH_q;
         reg [W-1:0] cntPh;
         reg rawH_d, rawL;
         wire endPer = (cnt_q >= per_q - {{(W-1){1'b0}}, 1'b1});
         wire extRst = extRstEn[i] & extRstIn[i];
         wire flt = faultSel[i] ? faultExt[i] : faultCmp[i];
         wire lim = limitSel[i] ? limitExt[i] : limitCmp[i];
         wire cutNow = (extRst & ~extRstVarPeriod[i]) | cut_q;
         always @* begin
            cntPh = cnt_q + phase_q;
            if (cntPh >= per_q)
               cntPh = cntPh - per_q;
            rawH_d = (cntPh < duty_q);
            if (chanMode[2*i+1 -: 2] == `MODE_PULSE)
               rawH_d = (cntPh == {W{1'b0}}) || (cntPh < duty_q && cntPh < dead_q + 1'b1);
            // A cut cycle stays off until the period ends, so the period length never moves.
            if (lim || cutNow)
               rawH_d = 1'b0;
            case (chanMode[2*i+1 -: 2])
               `MODE_COMPL: rawL = ~rawH_d;
               `MODE_MIRROR: rawL = rawH_d;
               `MODE_DUAL: rawL = (cntPh < duty2_q);
               `MODE_PULSE: rawL = 1'b0;
               default: rawL = 1'b0;
            endcase
         end
         always @(posedge clk) begin
            if (!rst_n) begin
               per_q <= `PERIOD_RST;
               duty_q <= 16'h0000;
               duty2_q <= 16'h0000;
               phase_q <= 16'h0000;
               dead_q <= 16'h0000;
               pPer_q <= `PERIOD_RST;
               pDuty_q <= 16'h0000;
               pDuty2_q <= 16'h0000;
               pPhase_q <= 16'h0000;
               pDead_q <= 16'h0000;
               pend_q <= 1'b0;
               cut_q <= 1'b0;
               cnt_q <= 16'h0000;
            end else begin
               if (extRst && !extRstVarPeriod[i])
                  cut_q <= 1'b1;
               else if (endPer)
                  cut_q <= 1'b0;
               if (groupAWrite && groupAMember[i]) begin
                  pPer_q <= grpAPeriod;
                  pDuty_q <= grpADuty;
                  pPhase_q <= grpAPhase;
                  pend_q <= 1'b1;
               end else if (groupBWrite && groupBMember[i]) begin
                  pPer_q <= grpBPeriod;
                  pDuty_q <= grpBDuty;
                  pPhase_q <= grpBPhase;
                  pend_q <= 1'b1;
               end else if (cfgWrite[i]) begin
                  pPer_q <= cfgPeriod[i*W +: W];
                  pDuty_q <= cfgDuty[i*W +: W];
                  pDuty2_q <= cfgDuty2[i*W +: W];
                  pPhase_q <= cfgPhase[i*W +: W];
                  pDead_q <= cfgDead[i*W +: W];
                  pend_q <= 1'b1;
               end else if (pend_q && (updImmediate || endPer)) begin
                  per_q <= pPer_q;
                  duty_q <= pDuty_q;
                  duty2_q <= pDuty2_q;
                  phase_q <= pPhase_q;
                  dead_q <= pDead_q;
                  pend_q <= 1'b0;
               end
               if (extRst && extRstVarPeriod[i])
                  cnt_q <= 16'h0000;
               else if (endPer)
                  cnt_q <= 16'h0000;
               else
                  cnt_q <= cnt_q + 16'h0001;
            end
         end
         // Dead-time counter forces both sides off after a raw state change in complementary mode with nonzero dead time.
         always @(posedge clk) begin
            if (!rst_n) begin
               rawH_q <= 1'b0;
               dtCnt_q <= 16'h0000;
               outH_q <= 1'b0;
               outL_q <= 1'b0;
               prevH_q <= 1'b0;
            end else begin
               rawH_q <= rawH_d;
               prevH_q <= outH_q;
               if (chanMode[2*i+1 -: 2] == `MODE_COMPL && rawH_d != rawH_q &&
                  dead_q != 16'h0000) begin
                  dtCnt_q <= dead_q - 16'h0001;
                  outH_q <= 1'b0;
                  outL_q <= 1'b0;
               end else if (chanMode[2*i+1 -: 2] == `MODE_COMPL && dtCnt_q != 16'h0000) begin
                  dtCnt_q <= dtCnt_q - 16'h0001;
                  outH_q <= 1'b0;
                  outL_q <= 1'b0;
               end else begin
                  dtCnt_q <= 16'h0000;
                  outH_q <= rawH_d;
                  outL_q <= rawL;
               end
            end
         end
         always @(posedge clk) begin
            if (!rst_n) begin
               pwm_high_side_out[i] <= 1'b0;
               pwm_low_side_out[i] <= 1'b0;
               faultActive[i] <= 1'b0;
            end else begin
               faultActive[i] <= flt;
               if (flt) begin
                  pwm_high_side_out[i] <= 1'b0;
                  pwm_low_side_out[i] <= 1'b0;
               end else if (swapOut[i]) begin
                  pwm_high_side_out[i] <= outL_q & (~chopEn[i] | chopClk_q | ~outL_q);
                  pwm_low_side_out[i] <= outH_q & (~chopEn[i] | chopClk_q | ~outH_q);
               end else begin
                  pwm_high_side_out[i] <= outH_q & (~chopEn[i] | chopClk_q);
                  pwm_low_side_out[i] <= outL_q & (~chopEn[i] | chopClk_q);
               end
            end
         end
         always @* begin
            riseEv[i] = outH_q & ~prevH_q;
            fallEv[i] = ~outH_q & prevH_q;
         end
      end
   endgenerate
   // Triggers follow channel 0 edges; blanking suppresses both after any trigger.
   always @(posedge clk) begin
      if (!rst_n) begin
         adcTrigRise <= 1'b0;
         adcTrigFall <= 1'b0;
         blankCnt_q <= 8'h00;
      end else begin
         adcTrigRise <= 1'b0;
         adcTrigFall <= 1'b0;
         if (blankCnt_q != 8'h00) begin
            blankCnt_q <= blankCnt_q - 8'h01;
         end else if (riseEv[0]) begin
            adcTrigRise <= 1'b1;
            blankCnt_q <= blankTime;
         end else if (fallEv[0]) begin
            adcTrigFall <= 1'b1;
            blankCnt_q <= blankTime;
         end
      end
   end
endmodule

// [rtl/power_pwm_regs.vh]
// What this block does
// - Six channels, each driving one low-side and one high-side output.
// - Per channel mode: complementary, mirrored, dual duty cycle or pulsed.
// - Low and high outputs of a channel can be swapped instantly.
// - Chopper clock gated onto outputs, conditioned on high and low output state.
// - External reset ends the cycle early, constant or variable period variant.
// - Edges placed with one timebase clock granularity.
// - Duty, dead time, phase and period programmable per output independently.
// - Two groups; one write updates frequency, duty and phase of all members.
// - New settings apply immediately or at end of current period.
// - Per output fault and current-limit inputs, from comparator or external source.
// - Two ADC triggers per period, rising and falling, with 8-bit blanking.
`ifndef POWER_PWM_REGS_VH
`define POWER_PWM_REGS_VH
`define PWM_CHANNELS 6
`define PWM_CNT_W 16
`define PWM_BLANK_W 8
`define MODE_COMPL 2'h0
`define MODE_MIRROR 2'h1
`define MODE_DUAL 2'h2
`define MODE_PULSE 2'h3
`define PERIOD_RST 16'h0064
`define CHOP_DIV_RST 8'h04
`endif

// [testbench/gate_stage_model.sv]
`timescale 1ns/1ns
module gate_stage_model (
   input wire clk, // Clock.
   input wire trigRise, // Rising trigger.
   input wire trigFall, // Falling trigger.
   input wire [5:0] faultReq, // Stage trips.
   input wire [5:0] limitReq, // Stage overcurrent.
   output reg [5:0] faultExt = 6'h00, // Fault back.
   output reg [5:0] limitExt = 6'h00, // Limit back.
   output reg [15:0] nRise = 16'h0000, // Rising triggers.
   output reg [15:0] nFall = 16'h0000 // Falling triggers.
);
   // The stage answers one falling edge late, like a real comparator path.
   always @(negedge clk) begin
      faultExt <= faultReq;
      limitExt <= limitReq;
   end
   always @(posedge clk) begin
      nRise <= nRise + trigRise;
      nFall <= nFall + trigFall;
   end
endmodule

// [testbench/pwm_monitor.sv]
`timescale 1ns/1ns
module pwm_monitor (
   input wire clk, // Clock.
   input wire rst_n, // Reset.
   input wire [11:0] chanMode, // Modes.
   input wire [5:0] swapOut, // Swaps.
   input wire [5:0] faultCmp, // Fault in.
   input wire [5:0] faultExt, // Fault in.
   input wire [5:0] faultSel, // Fault pick.
   input wire [5:0] limitCmp, // Limit in.
   input wire [5:0] limitExt, // Limit in.
   input wire [5:0] limitSel, // Limit pick.
   input wire [5:0] pwm_low_side_out, // Low gates.
   input wire [5:0] pwm_high_side_out, // High gates.
   input wire adcTrigRise, // Trigger.
   input wire adcTrigFall, // Trigger.
   input wire [5:0] faultActive // Fault flags.
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire [5:0] selF = (faultSel & faultExt) | (~faultSel & faultCmp);
   wire [5:0] selL = (limitSel & limitExt) | (~limitSel & limitCmp);
   // Antecedents repeat so that the output pipeline has drained first.
   sequence faultHeld; faultActive[0] [*3]; endsequence
   sequence pulsedHeld; (chanMode[1:0] == 2'h3 && !swapOut[0]) [*4]; endsequence
   no_overlap_a: assert property ((chanMode[1:0] == 2'h0) [*4] |->
      !(pwm_low_side_out[0] && pwm_high_side_out[0])) else $error("both gates on");
   fault_select_a: assert property ($stable(selF) [*3] |-> faultActive == selF)
      else $error("fault source");
   fault_hold_a: assert property (faultHeld |->
      (pwm_low_side_out[0] | pwm_high_side_out[0]) == 1'b0) else $error("gate on in fault");
   limit_high_a: assert property ((selL[0] && !swapOut[0]) [*5] |->
      !pwm_high_side_out[0]) else $error("high on in limit");
   pulse_low_a: assert property (pulsedHeld |-> !pwm_low_side_out[0])
      else $error("low on in pulsed");
   trig_apart_a: assert property (!(adcTrigRise && adcTrigFall))
      else $error("triggers together");
   trig_pulse_a: assert property (adcTrigRise |=> !adcTrigRise)
      else $error("trigger too long");
   reset_quiet_a: assert property ($rose(rst_n) |-> !adcTrigRise &&
      (pwm_low_side_out | pwm_high_side_out) == 6'h00) else $error("gates on at reset");
endmodule
bind six_channel_power_pwm pwm_monitor i_pwm_monitor (.clk, .rst_n, .chanMode, .swapOut,
   .faultCmp, .faultExt, .faultSel, .limitCmp, .limitExt, .limitSel, .pwm_low_side_out,
   .pwm_high_side_out, .adcTrigRise, .adcTrigFall, .faultActive);

// [testbench/tb_top.sv]
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks = n_checks + 1; if ((a) !== (b)) begin errors = errors + 1; \
   $display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
module tb_top;
   reg clk = 1'b0, rst_n = 1'b0, updImmediate = 1'b1, groupAWrite = 1'b0, groupBWrite = 1'b0;
   reg [11:0] chanMode = 12'h000;
   reg [5:0] swapOut = 6'h00, chopEn = 6'h00, extRstEn = 6'h00, extRstVarPeriod = 6'h00;
   reg [5:0] extRstIn = 6'h00, cfgWrite = 6'h00, groupAMember = 6'h00, groupBMember = 6'h00;
   reg [5:0] faultCmp = 6'h00, faultSel = 6'h00, limitCmp = 6'h00, limitSel = 6'h00;
   reg [5:0] faultReq = 6'h00, limitReq = 6'h00;
   reg [7:0] chopDiv = 8'h01, blankTime = 8'h00;
   reg [95:0] cfgPeriod = 96'h0, cfgDuty = 96'h0, cfgDuty2 = 96'h0, cfgPhase = 96'h0, cfgDead = 96'h0;
   reg [15:0] grpAPeriod = 16'h0014, grpADuty = 16'h0008, grpAPhase = 16'h0000;
   reg [15:0] grpBPeriod = 16'h0014, grpBDuty = 16'h0009, grpBPhase = 16'h0001;
   wire [5:0] faultExt, limitExt, pwm_low_side_out, pwm_high_side_out, faultActive;
   wire adcTrigRise, adcTrigFall;
   wire [15:0] nRise, nFall;
   integer errors = 0, n_checks = 0, i, r0, f0, hc[6], lc[6];
   six_channel_power_pwm i_six_channel_power_pwm (.clk, .rst_n, .chanMode, .swapOut, .chopEn,
      .chopDiv, .extRstEn, .extRstVarPeriod, .extRstIn, .cfgPeriod, .cfgDuty, .cfgDuty2, .cfgPhase,
      .cfgDead, .cfgWrite, .groupAMember, .groupBMember, .groupAWrite, .groupBWrite, .grpAPeriod,
      .grpADuty, .grpAPhase, .grpBPeriod, .grpBDuty, .grpBPhase, .updImmediate, .faultCmp,
      .faultExt, .faultSel, .limitCmp, .limitExt, .limitSel, .blankTime, .pwm_low_side_out,
      .pwm_high_side_out, .adcTrigRise, .adcTrigFall, .faultActive);
   gate_stage_model i_gate_stage_model (.clk, .trigRise(adcTrigRise), .trigFall(adcTrigFall),
      .faultReq, .limitReq, .faultExt, .limitExt, .nRise, .nFall);
   initial forever #10 clk = ~clk;
   task load(input integer off, input [15:0] dead); integer c; begin
      @(negedge clk);
      for (c = 0; c < 6; c = c + 1) begin
         cfgPeriod[c*16+:16] = 16'h0014;
         cfgDuty[c*16+:16] = 16'(c + off);
         cfgDuty2[c*16+:16] = 16'(c + off);
         cfgPhase[c*16+:16] = 16'(c);
         cfgDead[c*16+:16] = dead;
      end
      cfgWrite = 6'h3F;
      @(negedge clk);
      cfgWrite = 6'h00;
   end endtask
   // A window of one full 20-clock period, so phase never changes the counts.
   task meas(input integer settle); integer k; begin
      repeat (settle) @(negedge clk);
      r0 = nRise;
      f0 = nFall;
      for (k = 0; k < 6; k = k + 1) begin
         hc[k] = 0;
         lc[k] = 0;
      end
      repeat (20) begin
         @(negedge clk);
         for (k = 0; k < 6; k = k + 1) begin
            hc[k] = hc[k] + pwm_high_side_out[k];
            lc[k] = lc[k] + pwm_low_side_out[k];
         end
      end
   end endtask
   task give_verdict; begin
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   end endtask
   initial begin
      #2000000;
      errors = errors + 1;
      give_verdict;
   end
   initial begin
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      load(3, 16'h0000);
      meas(25);
      for (i = 0; i < 6; i = i + 1) begin
         `CHK(hc[i], i + 3)
         `CHK(lc[i], 17 - i)
      end
      `CHK(nRise - r0, 1)
      `CHK(nFall - f0, 1)
      $display("basic done");
      blankTime = 8'h0A;
      meas(25);
      `CHK(nRise - r0, 1)
      `CHK(nFall - f0, 0)
      blankTime = 8'h00;
      swapOut = 6'h01;
      meas(5);
      `CHK(hc[0], 17)
      `CHK(lc[0], 3)
      swapOut = 6'h00;
      groupAMember = 6'h03;
      groupBMember = 6'h04;
      groupAWrite = 1'b1;
      groupBWrite = 1'b1;
      @(negedge clk);
      groupAWrite = 1'b0;
      groupBWrite = 1'b0;
      meas(25);
      `CHK(hc[0], 8)
      `CHK(hc[1], 8)
      `CHK(hc[2], 9)
      `CHK(hc[3], 6)
      $display("swap and group done");
      load(3, 16'h0002);
      meas(25);
      for (i = 0; i < 6; i = i + 1) `CHK(hc[i] + lc[i], 16)
      for (i = 1; i < 4; i = i + 1) begin
         chanMode[1:0] = 2'(i);
         meas(25);
         `CHK(hc[0], 3)
      end
      chanMode = 12'h000;
      updImmediate = 1'b0;
      load(6, 16'h0000);
      meas(45);
      `CHK(hc[0], 6)
      $display("dead, modes and update done");
      faultCmp = 6'h02;
      faultSel = 6'h03;
      faultReq = 6'h01;
      meas(6);
      `CHK(faultActive, 6'h01)
      `CHK(hc[0] + lc[0], 0)
      `CHK(hc[1], 7)
      faultSel = 6'h00;
      meas(6);
      `CHK(faultActive, 6'h02)
      faultCmp = 6'h00;
      faultReq = 6'h00;
      limitSel = 6'h01;
      limitReq = 6'h01;
      limitCmp = 6'h02;
      meas(25);
      `CHK(hc[0], 0)
      `CHK(hc[1], 0)
      limitReq = 6'h00;
      limitCmp = 6'h00;
      chopEn = 6'h04;
      meas(25);
      `CHK(hc[2] < 8, 1'b1)
      chopEn = 6'h00;
      extRstEn = 6'h3F;
      extRstVarPeriod = 6'h01;
      extRstIn = 6'h09;
      meas(25);
      `CHK(hc[0], 20)
      `CHK(hc[3], 0)
      extRstIn = 6'h00;
      $display("fault, limit, chop and reset done");
      give_verdict;
   end
endmodule
